// ---- lsc_hv_stage_model.sv ----
// behavioural model of the high-voltage transistor stage on the line side
`timescale 1ns/10ps
module lsc_hv_stage_model (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic tip_drive_en_i,
  input  wire logic ring_drive_en_i,
  input  wire logic fault_i,
  output logic      power_alarm_o,
  output logic      tip_hiz_o,
  output logic      ring_hiz_o
);
  logic fault_r;
  assign tip_hiz_o  = ~tip_drive_en_i;
  assign ring_hiz_o = ~ring_drive_en_i;
  // overheating only while a side conducts
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r       <= 1'b0;
      power_alarm_o <= 1'b0;
    end else begin
      fault_r       <= fault_i;
      power_alarm_o <= fault_i & ~fault_r & (tip_drive_en_i | ring_drive_en_i);
    end
  end
endmodule : lsc_hv_stage_model

// ---- lsc_linefeed_ctrl.sv ----
// linefeed state control: dc feed settings, state decode, power alarm
//
// Functional notes
// - 6-bit open-circuit voltage, 0 to 94.5 V, 1.5 V per code.
// - 3-bit loop current limit, 20 to 41 mA, 3 mA per code.
// - reset defaults 20 mA, 48 V, 3 V; software programs them first.
// - 6-bit common-mode offset goes to TIP forward, RING reverse.
// - eight linefeed states, chosen by the linefeed register or forced open by auto-open.
// - open state: no drive to any transistor, both terminals high impedance.
// - device may force open state itself on excess transistor power.
// - forward and reverse active: drive on, audio paths powered down.
// - on-hook transmission states: drive on, audio paths powered up.
// - TIP open: TIP drive off, RING fed, for ground start.
// - RING open: RING drive off, TIP fed.
// - ringing: ringing generator drives line instead of dc feed.
// - codes: 0 open,1 fwd act,2 fwd oht,3 tip open,4 ring,5 rev act,6 rev oht,7 ring open.
// - power alarm sets status, interrupts if enabled, opens if auto-open.
`timescale 1ns/10ps
module lsc_linefeed_ctrl (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_sdi_i,
  output logic            spi_sdo_o,
  output logic            spi_sdo_oe_n_o,
  input  wire logic       power_alarm_i,
  output logic [2:0]      linefeed_state_field_o,
  output logic [2:0]      loop_current_limit_o,
  output logic [5:0]      open_circuit_voltage_o,
  output logic [5:0]      common_mode_offset_o,
  output logic            tip_drive_en_o,
  output logic            ring_drive_en_o,
  output logic            dc_feed_en_o,
  output logic            ringing_en_o,
  output logic            audio_path_en_o,
  output logic            cm_offset_on_ring_o,
  output logic            power_alarm_irq_o
);

  typedef struct packed {
    lsc_pkg::lsc_state_t ls;
    logic [2:0]          cur_limit;
    logic [5:0]          oc_volt;
    logic [5:0]          cm_offset;
    logic                auto_open_enable;
    logic                alarm_status;
    logic                alarm_irq_en;
    logic                tip_drv;
    logic                ring_drv;
    logic                dc_feed;
    logic                ringing;
    logic                audio;
    logic                cm_on_ring;
    logic                irq;
  } lsc_ctrl_st_t;

  localparam lsc_ctrl_st_t CTRL_RST = '{
    ls:        lsc_pkg::LS_RST,
    cur_limit: lsc_pkg::CUR_LIMIT_RST,
    oc_volt:   lsc_pkg::OC_VOLT_RST,
    cm_offset: lsc_pkg::CM_OFFSET_RST,
    default:   '0
  };

  lsc_ctrl_st_t r_r;
  lsc_ctrl_st_t r_nxt;

  lsc_reg_if reg_bus ();

  lsc_spi_slave u_spi (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .sclk_i     (spi_sclk_i),
    .cs_n_i     (spi_cs_n_i),
    .sdi_i      (spi_sdi_i),
    .sdo_o      (spi_sdo_o),
    .sdo_oe_n_o (spi_sdo_oe_n_o),
    .bus        (reg_bus.spi)
  );

  // read data mux, unmapped addresses read zero
  always_comb begin
    unique case (reg_bus.addr)
      lsc_pkg::ADDR_LINEFEED:   reg_bus.rdata = {5'h00, r_r.ls};
      lsc_pkg::ADDR_CUR_LIMIT:  reg_bus.rdata = {5'h00, r_r.cur_limit};
      lsc_pkg::ADDR_OC_VOLT:    reg_bus.rdata = {2'h0, r_r.oc_volt};
      lsc_pkg::ADDR_CM_OFFSET:  reg_bus.rdata = {2'h0, r_r.cm_offset};
      lsc_pkg::ADDR_ALARM_CTRL: reg_bus.rdata = {5'h00, r_r.alarm_irq_en, r_r.alarm_status,
                                                 r_r.auto_open_enable};
      default:                  reg_bus.rdata = 8'h00;
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    if (reg_bus.wr_stb) begin
      unique case (reg_bus.addr)
        lsc_pkg::ADDR_LINEFEED:  r_nxt.ls = lsc_pkg::lsc_state_t'(reg_bus.wdata[2:0]);
        lsc_pkg::ADDR_CUR_LIMIT: r_nxt.cur_limit = reg_bus.wdata[lsc_pkg::CUR_LIMIT_W-1:0];
        lsc_pkg::ADDR_OC_VOLT:   r_nxt.oc_volt = reg_bus.wdata[lsc_pkg::OC_VOLT_W-1:0];
        lsc_pkg::ADDR_CM_OFFSET: r_nxt.cm_offset = reg_bus.wdata[lsc_pkg::CM_OFFSET_W-1:0];
        lsc_pkg::ADDR_ALARM_CTRL: begin
          r_nxt.auto_open_enable = reg_bus.wdata[lsc_pkg::ALARM_AUTO_OPEN_BIT];
          r_nxt.alarm_irq_en     = reg_bus.wdata[lsc_pkg::ALARM_IRQ_EN_BIT];
          if (reg_bus.wdata[lsc_pkg::ALARM_STATUS_BIT]) begin
            r_nxt.alarm_status = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (power_alarm_i) begin
      r_nxt.alarm_status = 1'b1;
    end
    // forced open overrides a same-cycle state write
    if (power_alarm_i && r_r.auto_open_enable) begin
      r_nxt.ls = lsc_pkg::LS_OPEN;
    end
    r_nxt.irq = r_nxt.alarm_status & r_nxt.alarm_irq_en;
    // state decode from next value, so outputs track the register
    r_nxt.tip_drv    = 1'b0;
    r_nxt.ring_drv   = 1'b0;
    r_nxt.dc_feed    = 1'b0;
    r_nxt.ringing    = 1'b0;
    r_nxt.audio      = 1'b0;
    r_nxt.cm_on_ring = 1'b0;
    unique case (r_nxt.ls)
      lsc_pkg::LS_OPEN: ;
      lsc_pkg::LS_FWD_ACTIVE: begin
        r_nxt.tip_drv  = 1'b1;
        r_nxt.ring_drv = 1'b1;
        r_nxt.dc_feed  = 1'b1;
      end
      lsc_pkg::LS_FWD_OHT: begin
        r_nxt.tip_drv  = 1'b1;
        r_nxt.ring_drv = 1'b1;
        r_nxt.dc_feed  = 1'b1;
        r_nxt.audio    = 1'b1;
      end
      lsc_pkg::LS_TIP_OPEN: begin
        r_nxt.ring_drv = 1'b1;
        r_nxt.dc_feed  = 1'b1;
      end
      lsc_pkg::LS_RINGING: begin
        r_nxt.tip_drv  = 1'b1;
        r_nxt.ring_drv = 1'b1;
        r_nxt.ringing  = 1'b1;
      end
      lsc_pkg::LS_REV_ACTIVE: begin
        r_nxt.tip_drv    = 1'b1;
        r_nxt.ring_drv   = 1'b1;
        r_nxt.dc_feed    = 1'b1;
        r_nxt.cm_on_ring = 1'b1;
      end
      lsc_pkg::LS_REV_OHT: begin
        r_nxt.tip_drv    = 1'b1;
        r_nxt.ring_drv   = 1'b1;
        r_nxt.dc_feed    = 1'b1;
        r_nxt.audio      = 1'b1;
        r_nxt.cm_on_ring = 1'b1;
      end
      lsc_pkg::LS_RING_OPEN: begin
        r_nxt.tip_drv = 1'b1;
        r_nxt.dc_feed = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_r <= CTRL_RST;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign linefeed_state_field_o = r_r.ls;
  assign loop_current_limit_o   = r_r.cur_limit;
  assign open_circuit_voltage_o = r_r.oc_volt;
  assign common_mode_offset_o   = r_r.cm_offset;
  assign tip_drive_en_o         = r_r.tip_drv;
  assign ring_drive_en_o        = r_r.ring_drv;
  assign dc_feed_en_o           = r_r.dc_feed;
  assign ringing_en_o           = r_r.ringing;
  assign audio_path_en_o        = r_r.audio;
  assign cm_offset_on_ring_o    = r_r.cm_on_ring;
  assign power_alarm_irq_o      = r_r.irq;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence state_write_s;
    ce_i && reg_bus.wr_stb && reg_bus.addr == lsc_pkg::ADDR_LINEFEED && !power_alarm_i;
  endsequence

  sequence alarm_open_s;
    ce_i && power_alarm_i && r_r.auto_open_enable;
  endsequence

  state_write_a: assert property (
    state_write_s |=> linefeed_state_field_o == $past(reg_bus.wdata[2:0])
      && (dc_feed_en_o || ringing_en_o) == ($past(reg_bus.wdata[2:0]) != 3'h0))
    else $error("state write not seen on decode next cycle");

  reset_defaults_a: assert property (
    !$past(rst_n_i) |-> loop_current_limit_o == 3'h0 && open_circuit_voltage_o == 6'h20
      && common_mode_offset_o == 6'h02 && linefeed_state_field_o == 3'h0)
    else $error("settings not at defaults after reset");

  oc_volt_a: assert property (
    ce_i && reg_bus.wr_stb && reg_bus.addr == lsc_pkg::ADDR_OC_VOLT
      |=> open_circuit_voltage_o == $past(reg_bus.wdata[5:0]))
    else $error("open-circuit voltage write lost");

  cur_limit_a: assert property (
    ce_i && reg_bus.wr_stb && reg_bus.addr == lsc_pkg::ADDR_CUR_LIMIT
      |=> loop_current_limit_o == $past(reg_bus.wdata[2:0]))
    else $error("current limit write lost");

  open_state_a: assert property (
    linefeed_state_field_o == 3'h0 |-> !tip_drive_en_o && !ring_drive_en_o
      && !dc_feed_en_o && !ringing_en_o && !audio_path_en_o)
    else $error("drive active in open state");

  alarm_open_a: assert property (
    alarm_open_s |=> linefeed_state_field_o == 3'h0 && !tip_drive_en_o ##1 1'b1)
    else $error("power alarm did not force open");

  alarm_flag_a: assert property (
    ce_i && power_alarm_i |=> r_r.alarm_status
      && power_alarm_irq_o == r_r.alarm_irq_en)
    else $error("power alarm flag or interrupt wrong");

  alarm_keep_a: assert property (
    ce_i && power_alarm_i && !r_r.auto_open_enable && !reg_bus.wr_stb
      |=> $stable(linefeed_state_field_o))
    else $error("state changed by alarm without auto-open");

  active_audio_a: assert property (
    linefeed_state_field_o inside {3'h1, 3'h5} |-> !audio_path_en_o
      && tip_drive_en_o && ring_drive_en_o && dc_feed_en_o)
    else $error("active state decode wrong");

  oht_audio_a: assert property (
    linefeed_state_field_o inside {3'h2, 3'h6} |-> audio_path_en_o && dc_feed_en_o)
    else $error("on-hook transmission decode wrong");

  tip_open_a: assert property (
    linefeed_state_field_o == 3'h3 |-> !tip_drive_en_o && ring_drive_en_o)
    else $error("tip open decode wrong");

  ring_open_a: assert property (
    linefeed_state_field_o == 3'h7 |-> tip_drive_en_o && !ring_drive_en_o)
    else $error("ring open decode wrong");

  ringing_sel_a: assert property (
    ringing_en_o == (linefeed_state_field_o == 3'h4) && !(ringing_en_o && dc_feed_en_o))
    else $error("ringing decode wrong");

  cm_polarity_a: assert property (
    cm_offset_on_ring_o == (linefeed_state_field_o inside {3'h5, 3'h6}))
    else $error("offset terminal wrong for polarity");

endmodule : lsc_linefeed_ctrl

// ---- lsc_linefeed_ctrl_tb.sv ----
// self-checking testbench for the linefeed state control block
`timescale 1ns/10ps
module lsc_linefeed_ctrl_tb;
  logic       clock_i, rst_n_i, ce_i, sclk, cs_n, sdi, fault, alarm;
  logic       sdo, sdo_oe_n, tip_hiz, ring_hiz;
  logic       tip_en, ring_en, dc_en, rgen, audio, cm_ring, irq;
  logic [2:0] lf_state, cur_lim;
  logic [5:0] oc_volt, cm_off;
  logic [7:0] rd;
  logic [2:0] exp_state;
  int         err_total;
  int         checked;
  int         cycles;
  // tip, ring, dc feed, ringing, audio per state code
  logic [4:0] dec_tbl [8] = '{5'h00, 5'h1c, 5'h1d, 5'h0c, 5'h1a, 5'h1c, 5'h1d, 5'h14};

  lsc_linefeed_ctrl u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n), .power_alarm_i(alarm),
    .linefeed_state_field_o(lf_state), .loop_current_limit_o(cur_lim),
    .open_circuit_voltage_o(oc_volt), .common_mode_offset_o(cm_off),
    .tip_drive_en_o(tip_en), .ring_drive_en_o(ring_en), .dc_feed_en_o(dc_en),
    .ringing_en_o(rgen), .audio_path_en_o(audio), .cm_offset_on_ring_o(cm_ring),
    .power_alarm_irq_o(irq)
  );

  lsc_hv_stage_model u_hv (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .tip_drive_en_i(tip_en),
    .ring_drive_en_i(ring_en), .fault_i(fault), .power_alarm_o(alarm),
    .tip_hiz_o(tip_hiz), .ring_hiz_o(ring_hiz)
  );

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // one frame: command byte then data byte, msb first
  task automatic spi(input logic rdn, input logic [6:0] a, input logic [7:0] wd,
                     output logic [7:0] rv);
    logic [15:0] sh;
    sh = {rdn, a, wd};
    rv = 8'h00;
    tick(1);
    cs_n <= 1'b0;
    tick(5);
    for (int i = 15; i >= 0; i--) begin
      sdi <= sh[i];
      tick(5);
      sclk <= 1'b1;
      if (i < 8) rv[i] = sdo;
      if (rdn && i == 7) chk(8'(sdo_oe_n), 8'h00);
      if (i == 0 && !rdn && a == lsc_pkg::ADDR_LINEFEED) begin
        tick(3);
        #1;
        chk(8'(lf_state), 8'(exp_state));
        tick(1);
        #1;
        exp_state = wd[2:0];
        chk(8'(lf_state), 8'(exp_state));
        tick(1);
      end else tick(5);
      sclk <= 1'b0;
    end
    tick(5);
    cs_n <= 1'b1;
    tick(6);
    if (rdn) chk(8'(sdo_oe_n), 8'h01);
  endtask : spi

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    spi(1'b0, a, d, dummy);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    spi(1'b1, a, 8'h00, rd);
    chk(rd, exp);
  endtask : rd_chk

  task automatic test_reset_values;
    #1;
    chk({2'h0, oc_volt}, {2'h0, lsc_pkg::OC_VOLT_RST});
    chk({2'h0, cm_off}, {2'h0, lsc_pkg::CM_OFFSET_RST});
    chk({cur_lim, lf_state, tip_en, ring_en}, 8'h00);
    rd_chk(lsc_pkg::ADDR_CUR_LIMIT, 8'h00);
    rd_chk(lsc_pkg::ADDR_OC_VOLT, 8'h20);
    rd_chk(lsc_pkg::ADDR_CM_OFFSET, 8'h02);
  endtask : test_reset_values

  task automatic test_feed_settings;
    logic [7:0] vals [2] = '{8'hff, 8'h15};
    for (int i = 0; i < 2; i++) begin
      wr(lsc_pkg::ADDR_CUR_LIMIT, vals[i]);
      wr(lsc_pkg::ADDR_OC_VOLT, vals[i]);
      wr(lsc_pkg::ADDR_CM_OFFSET, vals[i]);
      #1;
      chk(8'(cur_lim), vals[i] & 8'h07);
      chk(8'(oc_volt), vals[i] & 8'h3f);
      chk(8'(cm_off), vals[i] & 8'h3f);
      rd_chk(lsc_pkg::ADDR_CUR_LIMIT, vals[i] & 8'h07);
      rd_chk(lsc_pkg::ADDR_OC_VOLT, vals[i] & 8'h3f);
      rd_chk(lsc_pkg::ADDR_CM_OFFSET, vals[i] & 8'h3f);
    end
  endtask : test_feed_settings

  task automatic test_state_decode;
    logic [2:0] c;
    for (int i = 1; i <= 8; i++) begin
      c = 3'(i % 8);
      wr(lsc_pkg::ADDR_LINEFEED, {5'h15, c});
      #1;
      chk({3'h0, tip_en, ring_en, dc_en, rgen, audio}, 8'(dec_tbl[c]));
      chk({6'h00, tip_hiz, ring_hiz}, {6'h00, ~dec_tbl[c][4:3]});
      if (c[1:0] == 2'h1 || c[1:0] == 2'h2) chk(8'(cm_ring), 8'(c[2]));
      rd_chk(lsc_pkg::ADDR_LINEFEED, 8'(c));
    end
  endtask : test_state_decode

  task automatic test_unmapped;
    wr(7'h41, 8'haa);
    rd_chk(7'h41, 8'h00);
    rd_chk(lsc_pkg::ADDR_LINEFEED, 8'(exp_state));
  endtask : test_unmapped

  task automatic test_power_alarm;
    wr(lsc_pkg::ADDR_ALARM_CTRL, 8'h04);
    wr(lsc_pkg::ADDR_LINEFEED, 8'h01);
    fault <= 1'b1;
    tick(4);
    #1;
    chk({6'h00, irq, lf_state == 3'h1}, 8'h03);
    tick(1);
    fault <= 1'b0;
    rd_chk(lsc_pkg::ADDR_ALARM_CTRL, 8'h06);
    wr(lsc_pkg::ADDR_ALARM_CTRL, 8'h06);
    rd_chk(lsc_pkg::ADDR_ALARM_CTRL, 8'h04);
    chk(8'(irq), 8'h00);
    wr(lsc_pkg::ADDR_ALARM_CTRL, 8'h01);
    fault <= 1'b1;
    tick(4);
    #1;
    chk({irq, lf_state, tip_en, ring_en, dc_en}, 8'h00);
    exp_state = 3'h0;
    tick(1);
    fault <= 1'b0;
    rd_chk(lsc_pkg::ADDR_ALARM_CTRL, 8'h03);
  endtask : test_power_alarm

  // alarm pulse while frozen must be missed
  task automatic test_clock_enable;
    wr(lsc_pkg::ADDR_ALARM_CTRL, 8'h03);
    wr(lsc_pkg::ADDR_LINEFEED, 8'h05);
    ce_i  <= 1'b0;
    fault <= 1'b1;
    tick(4);
    fault <= 1'b0;
    tick(2);
    ce_i <= 1'b1;
    tick(2);
    #1;
    chk({5'h00, lf_state}, 8'(exp_state));
    rd_chk(lsc_pkg::ADDR_ALARM_CTRL, 8'h01);
  endtask : test_clock_enable

  // reset in mid-run restores defaults
  task automatic test_mid_reset;
    wr(lsc_pkg::ADDR_OC_VOLT, 8'h05);
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    exp_state = 3'h0;
    tick(1);
    #1;
    chk({2'h0, oc_volt}, {2'h0, lsc_pkg::OC_VOLT_RST});
    chk({2'h0, cm_off}, {2'h0, lsc_pkg::CM_OFFSET_RST});
    chk({5'h00, lf_state}, 8'(exp_state));
    tick(2);
    rd_chk(lsc_pkg::ADDR_ALARM_CTRL, 8'h00);
  endtask : test_mid_reset

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    err_total = 0;
    checked   = 0;
    cycles    = 0;
    exp_state = 3'h0;
    rst_n_i   = 1'b0;
    ce_i      = 1'b1;
    sclk      = 1'b0;
    cs_n      = 1'b1;
    sdi       = 1'b0;
    fault     = 1'b0;
    tick(6);
    rst_n_i <= 1'b1;
    tick(3);
    test_reset_values();
    test_feed_settings();
    test_state_decode();
    test_unmapped();
    test_power_alarm();
    test_clock_enable();
    test_mid_reset();
    print_verdict();
  end
endmodule : lsc_linefeed_ctrl_tb

// ---- lsc_pkg.sv ----
// constants and types shared by the linefeed state control block
package lsc_pkg;

  // register addresses on the serial control port
  localparam logic [6:0] ADDR_LINEFEED   = 7'h40;
  localparam logic [6:0] ADDR_CUR_LIMIT  = 7'h47;
  localparam logic [6:0] ADDR_OC_VOLT    = 7'h48;
  localparam logic [6:0] ADDR_CM_OFFSET  = 7'h49;
  localparam logic [6:0] ADDR_ALARM_CTRL = 7'h4a;

  // field widths
  localparam int CUR_LIMIT_W = 3;
  localparam int OC_VOLT_W   = 6;
  localparam int CM_OFFSET_W = 6;

  // reset values: 20 mA, 48 V, 3 V
  localparam logic [2:0] CUR_LIMIT_RST = 3'h0;
  localparam logic [5:0] OC_VOLT_RST   = 6'h20;
  localparam logic [5:0] CM_OFFSET_RST = 6'h02;

  // alarm control register bit positions
  localparam int ALARM_AUTO_OPEN_BIT = 0;
  localparam int ALARM_STATUS_BIT    = 1;
  localparam int ALARM_IRQ_EN_BIT    = 2;

  // command byte: bit 7 set means read
  localparam int SPI_READ_BIT = 7;

  // linefeed operating states, codes fixed by the hardware
  typedef enum logic [2:0] {
    LS_OPEN        = 3'h0,
    LS_FWD_ACTIVE  = 3'h1,
    LS_FWD_OHT     = 3'h2,
    LS_TIP_OPEN    = 3'h3,
    LS_RINGING     = 3'h4,
    LS_REV_ACTIVE  = 3'h5,
    LS_REV_OHT     = 3'h6,
    LS_RING_OPEN   = 3'h7
  } lsc_state_t;

  localparam lsc_state_t LS_RST = LS_OPEN;

endpackage : lsc_pkg

// ---- lsc_reg_if.sv ----
// register access carrier between serial slave and register file
`timescale 1ns/10ps
interface lsc_reg_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic [7:0] rdata;

  modport spi  (output addr, output wdata, output wr_stb, input rdata);
  modport regs (input addr, input wdata, input wr_stb, output rdata);
endinterface : lsc_reg_if

// ---- lsc_spi_slave.sv ----
// oversampled serial control port slave
`timescale 1ns/10ps
module lsc_spi_slave (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic sdi_i,
  output logic      sdo_o,
  output logic      sdo_oe_n_o,
  lsc_reg_if.spi    bus
);

  typedef struct packed {
    logic       sclk_s1;
    logic       sclk_s2;
    logic       sclk_d;
    logic       cs_n_s1;
    logic       cs_n_s2;
    logic       sdi_s1;
    logic       sdi_s2;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [6:0] addr;
    logic       rd;
    logic       load_pend;
    logic       wr_stb;
    logic       sdo;
    logic       sdo_oe_n;
  } lsc_spi_st_t;

  localparam lsc_spi_st_t SPI_RST = '{cs_n_s1: 1'b1, cs_n_s2: 1'b1, sdo_oe_n: 1'b1, default: '0};

  lsc_spi_st_t s_r;
  lsc_spi_st_t s_nxt;

  logic rise;
  logic fall;

  assign rise = s_r.sclk_s2 & ~s_r.sclk_d;
  assign fall = ~s_r.sclk_s2 & s_r.sclk_d;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.sclk_s1 = sclk_i;
    s_nxt.sclk_s2 = s_r.sclk_s1;
    s_nxt.sclk_d  = s_r.sclk_s2;
    s_nxt.cs_n_s1 = cs_n_i;
    s_nxt.cs_n_s2 = s_r.cs_n_s1;
    s_nxt.sdi_s1  = sdi_i;
    s_nxt.sdi_s2  = s_r.sdi_s1;
    s_nxt.wr_stb  = 1'b0;
    s_nxt.load_pend = 1'b0;
    if (s_r.load_pend) begin
      s_nxt.tx = bus.rdata;
    end
    if (s_r.cs_n_s2) begin
      s_nxt.bit_cnt  = '0;
      s_nxt.byte_idx = '0;
      s_nxt.sdo_oe_n = 1'b1;
    end else begin
      if (rise && s_r.byte_idx != 2'h2) begin
        s_nxt.shift   = {s_r.shift[6:0], s_r.sdi_s2};
        s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
        if (s_r.bit_cnt == 3'h7) begin
          s_nxt.byte_idx = s_r.byte_idx + 2'h1;
          if (s_r.byte_idx == 2'h0) begin
            s_nxt.addr      = s_nxt.shift[6:0];
            s_nxt.rd        = s_nxt.shift[lsc_pkg::SPI_READ_BIT];
            s_nxt.load_pend = 1'b1;
          end else if (!s_r.rd) begin
            s_nxt.wr_stb = 1'b1;
          end
        end
      end
      if (fall && s_r.byte_idx == 2'h1 && s_r.rd) begin
        s_nxt.sdo      = s_r.tx[7];
        s_nxt.tx       = {s_r.tx[6:0], 1'b0};
        s_nxt.sdo_oe_n = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= SPI_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign bus.addr   = s_r.addr;
  assign bus.wdata  = s_r.shift;
  assign bus.wr_stb = s_r.wr_stb;
  assign sdo_o      = s_r.sdo;
  assign sdo_oe_n_o = s_r.sdo_oe_n;

  wr_pulse_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i) ce_i && s_r.wr_stb |=> !s_r.wr_stb)
    else $error("write strobe lasted more than one cycle");

endmodule : lsc_spi_slave
